// ==== rtl/ldss_defs.svh ====
// Constants for the table, source select and power-up sequencing block
// Function
// (R1) Two tables of sixty-four bytes each
// (R2) Row address is table base plus index
// (R3) Default index is converter result upper six bits
// (R4) Bypass takes index from row-select register
// (R5) Channel one code source three-way select
// (R6) Channel two same select, own bits
// (R7) Shared result, otherwise independent channels
// (R8) Code-direct uses control register three/four
// (R9) Per-channel direction bit in register zero
// (R10) Two-bit full-scale field per channel
// (R11) Full-scale codes: external, 0.4, 0.85, 1.3
// (R12) Recall settings before enabling analog circuits
// (R13) Load codes after four identical conversions
// (R14) Codes held zero until first lookup
// (R15) Filter disabled: one conversion suffices
// (R16) Recalled selects steer the first load
// (R17) Result updates after four six-bit matches
// (R18) New reset restarts the whole sequence
// (R19) Mismatch restarts the match counter
`ifndef LDSS_DEFS_SVH
`define LDSS_DEFS_SVH

// ----------------------------------------
// Register indices (byte address is four times)
// ----------------------------------------
`define LDSS_IDX_CTRL0 9'h080
`define LDSS_IDX_CTRL1 9'h081
`define LDSS_IDX_CTRL2 9'h082
`define LDSS_IDX_CTRL3 9'h083
`define LDSS_IDX_CTRL4 9'h084
`define LDSS_IDX_CTRL5 9'h085
`define LDSS_IDX_STATUS 9'h087
`define LDSS_IDX_RSV_LO 9'h088
`define LDSS_IDX_RSV_HI 9'h08F
`define LDSS_TBL1_BASE 9'h090
`define LDSS_TBL2_BASE 9'h0D0
`define LDSS_TBL_END 9'h10F
`define LDSS_NUM_CTRL 6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LDSS_C0_DIR1 0
`define LDSS_C0_DIR2 1
`define LDSS_C0_FILT_OFF 7
`define LDSS_C5_FS1_LO 0
`define LDSS_C5_FS2_LO 2
`define LDSS_C5_ROW1 4
`define LDSS_C5_CODE1 5
`define LDSS_C5_ROW2 6
`define LDSS_C5_CODE2 7

// ----------------------------------------
// Values and counts
// ----------------------------------------
`define LDSS_CTRL_RESET 8'h00
`define LDSS_CODE_ZERO 8'h00
`define LDSS_FS_EXTERNAL 2'h0
`define LDSS_FS_0P40MA 2'h1
`define LDSS_FS_0P85MA 2'h2
`define LDSS_FS_1P30MA 2'h3
`define LDSS_MATCH_LAST 3'h3
`define LDSS_MATCH_FIRST 3'h1
`define LDSS_MATCH_NONE 3'h0
`define LDSS_ROWS 64

`endif

// ==== rtl/ldss_pkg.sv ====
// Types shared by the table and source select block
package ldss_pkg;
    typedef enum logic [1:0] {
        LDSS_RECALL = 2'b00,
        LDSS_POWER = 2'b01,
        LDSS_QUALIFY = 2'b10,
        LDSS_RUN = 2'b11
    } ldss_state_e;

    typedef struct packed {
        logic row_direct;
        logic code_direct;
        logic [5:0] reg_row;
        logic [7:0] direct_code;
    } ldss_chan_s;
endpackage

// ==== rtl/ldss_tables.sv ====
// Two row tables with a bus port and one lookup port per channel
`timescale 1ns/1ps
`include "ldss_defs.svh"
module ldss_tables
(
    // Clock and factory preset
    input wire logic clk,
    input wire logic factory_init,
    // Bus port
    input wire logic wr_en,
    input wire logic wr_tbl,
    input wire logic [5:0] wr_row,
    input wire logic [7:0] wr_data,
    input wire logic rd_tbl,
    input wire logic [5:0] rd_row,
    output logic [7:0] rd_data,
    // Lookup ports
    input wire logic [5:0] look_row_one,
    input wire logic [5:0] look_row_two,
    output logic [7:0] look_one,
    output logic [7:0] look_two
);
    logic [7:0] rd_word [0:1];
    logic [7:0] look_word [0:1];
    logic [5:0] look_row [0:1];

    assign look_row[0] = look_row_one;
    assign look_row[1] = look_row_two;

    genvar t;
    generate
        for (t = 0; t < 2; t = t + 1)
        begin : gen_tbl
            // Not reset by RST: contents are nonvolatile
            logic [7:0] mem [0:`LDSS_ROWS-1];
            always_ff @(posedge clk)
            begin
                if (factory_init)
                begin
                    for (int i = 0; i < `LDSS_ROWS; i++)
                    begin
                        mem[i] <= `LDSS_CODE_ZERO;
                    end
                end
                else if (wr_en && (wr_tbl == 1'(t)))
                begin
                    mem[wr_row] <= wr_data; // R1
                end
            end
            assign rd_word[t] = mem[rd_row];
            assign look_word[t] = mem[look_row[t]];
        end
    endgenerate

    assign rd_data = rd_word[rd_tbl];
    assign look_one = look_word[0]; // R1
    assign look_two = look_word[1]; // R1
endmodule // ldss_tables

// ==== rtl/ldss_conv_filter.sv ====
// Qualifying filter for converter results
`timescale 1ns/1ps
`include "ldss_defs.svh"
module ldss_conv_filter
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Conversions
    input wire logic valid,
    input wire logic [7:0] data,
    input wire logic filter_disable,
    // Qualified result
    output logic [7:0] result,
    output logic update
);
    logic [7:0] prev_reg;
    logic [7:0] result_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic upd_reg;
    wire same_top = (data[7:2] == prev_reg[7:2]);
    wire fourth = same_top && (cnt_reg == `LDSS_MATCH_LAST);
    wire upd_now = valid && (filter_disable || fourth); // R15 R17

    // Mismatch or fresh start counts this conversion as the first
    assign cnt_next = !valid ? cnt_reg :
                      filter_disable ? `LDSS_MATCH_NONE :
                      fourth ? `LDSS_MATCH_NONE :
                      (!same_top || cnt_reg == `LDSS_MATCH_NONE) ? `LDSS_MATCH_FIRST : // R19
                      cnt_reg + 3'h1;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_reg <= `LDSS_CODE_ZERO;
            result_reg <= `LDSS_CODE_ZERO;
            cnt_reg <= `LDSS_MATCH_NONE;
            upd_reg <= 1'b0;
        end
        else
        begin
            if (valid)
            begin
                prev_reg <= data;
            end
            if (upd_now)
            begin
                result_reg <= data; // R17
            end
            cnt_reg <= cnt_next;
            upd_reg <= upd_now;
        end
    end

    assign result = result_reg;
    assign update = upd_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    four_match_a: assert property (@(posedge clk) disable iff (rst) // R17
        upd_reg && !$past(filter_disable) |-> $past(cnt_reg) == `LDSS_MATCH_LAST)
        else $error("filtered update without four matches");
    unfiltered_a: assert property (@(posedge clk) disable iff (rst) // R15
        valid && filter_disable |=> upd_reg && result_reg == $past(data))
        else $error("unfiltered conversion not taken");
    restart_cnt_a: assert property (@(posedge clk) disable iff (rst) // R19
        valid && !filter_disable && !same_top |=> cnt_reg == `LDSS_MATCH_FIRST)
        else $error("match counter did not restart");
endmodule // ldss_conv_filter

// ==== rtl/ldss_top.sv ====
// Table lookup, DAC source selection and power-up sequencing with APB registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ldss_defs.svh"
module ldss_top
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic FACTORY_INIT,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [10:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter
    input wire logic CONV_READY,
    input wire logic CONV_VALID,
    input wire logic [7:0] CONV_DATA,
    output logic CONV_ENABLE,
    output logic ANALOG_ENABLE,
    // Current generators
    output logic [7:0] DAC1_CODE,
    output logic [7:0] DAC2_CODE,
    output logic CHAN1_DIR,
    output logic CHAN2_DIR,
    output logic [1:0] CHAN1_FS,
    output logic [1:0] CHAN2_FS
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic is_table(input logic [8:0] idx);
        is_table = (idx >= `LDSS_TBL1_BASE) && (idx <= `LDSS_TBL_END);
    endfunction

    function automatic logic table_of(input logic [8:0] idx);
        table_of = (idx >= `LDSS_TBL2_BASE);
    endfunction

    function automatic logic [5:0] row_of(input logic [8:0] idx);
        logic [8:0] diff;
        diff = idx - (table_of(idx) ? `LDSS_TBL2_BASE : `LDSS_TBL1_BASE);
        row_of = diff[5:0];
    endfunction

    function automatic logic [7:0] dac_src(input logic direct, input logic [7:0] code,
                                           input logic [7:0] row_byte);
        dac_src = direct ? code : row_byte;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ldss_pkg::ldss_state_e state_reg;
    ldss_pkg::ldss_state_e state_next;
    logic [7:0] ctrl_reg [0:`LDSS_NUM_CTRL-1];
    logic [7:0] ctrl_nv [0:`LDSS_NUM_CTRL-1];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    logic [7:0] dac1_reg;
    logic [7:0] dac2_reg;
    logic analog_reg;
    logic conv_en_reg;
    logic [7:0] result;
    logic filt_update;
    logic [7:0] look_one;
    logic [7:0] look_two;
    logic [7:0] tbl_rd;
    ldss_pkg::ldss_chan_s chan_one;
    ldss_pkg::ldss_chan_s chan_two;

    wire [8:0] idx = PADDR[10:2];
    wire access = PSEL && PENABLE && pready_reg;
    wire wr_hit = access && PWRITE;
    wire idx_ctrl = (idx >= `LDSS_IDX_CTRL0) && (idx <= `LDSS_IDX_CTRL5);
    wire idx_rsv = (idx >= `LDSS_IDX_RSV_LO) && (idx <= `LDSS_IDX_RSV_HI);
    wire idx_ok = idx_ctrl || idx_rsv || (idx == `LDSS_IDX_STATUS) || is_table(idx);
    wire [2:0] ctrl_sel = idx[2:0];
    wire tbl_wr = wr_hit && is_table(idx);
    wire recall = (state_reg == ldss_pkg::LDSS_RECALL);
    wire filt_off = ctrl_reg[0][`LDSS_C0_FILT_OFF];
    wire conv_take = CONV_VALID && (state_reg == ldss_pkg::LDSS_QUALIFY ||
                                    state_reg == ldss_pkg::LDSS_RUN);

    // ----------------------------------------
    // Control registers: nonvolatile copy and working copy
    // ----------------------------------------
    genvar r;
    generate
        for (r = 0; r < `LDSS_NUM_CTRL; r = r + 1)
        begin : gen_ctrl
            wire hit = wr_hit && idx_ctrl && (ctrl_sel == 3'(r));
            // Nonvolatile copy survives RST
            always_ff @(posedge CLOCK)
            begin
                if (FACTORY_INIT)
                begin
                    ctrl_nv[r] <= `LDSS_CTRL_RESET;
                end
                else if (hit)
                begin
                    ctrl_nv[r] <= PWDATA[7:0];
                end
            end
            always_ff @(posedge CLOCK)
            begin
                if (RST)
                begin
                    ctrl_reg[r] <= `LDSS_CTRL_RESET;
                end
                else if (recall)
                begin
                    ctrl_reg[r] <= ctrl_nv[r]; // R12
                end
                else if (hit)
                begin
                    ctrl_reg[r] <= PWDATA[7:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Channel settings, each from its own bits
    // ----------------------------------------
    assign chan_one = '{row_direct: ctrl_reg[5][`LDSS_C5_ROW1],
                        code_direct: ctrl_reg[5][`LDSS_C5_CODE1],
                        reg_row: ctrl_reg[1][5:0],
                        direct_code: ctrl_reg[3]}; // R7 R8
    assign chan_two = '{row_direct: ctrl_reg[5][`LDSS_C5_ROW2],
                        code_direct: ctrl_reg[5][`LDSS_C5_CODE2],
                        reg_row: ctrl_reg[2][5:0],
                        direct_code: ctrl_reg[4]}; // R7 R8

    wire [5:0] row_one = chan_one.row_direct ? chan_one.reg_row : result[7:2]; // R3 R4
    wire [5:0] row_two = chan_two.row_direct ? chan_two.reg_row : result[7:2]; // R3 R4
    wire [8:0] look_addr_one = `LDSS_TBL1_BASE + {3'h0, row_one}; // R2
    wire [8:0] look_addr_two = `LDSS_TBL2_BASE + {3'h0, row_two}; // R2
    wire run = (state_reg == ldss_pkg::LDSS_RUN);
    // Zero until the first qualified lookup; selects already recalled
    wire [7:0] dac1_next = run ? dac_src(chan_one.code_direct, chan_one.direct_code,
                                         look_one) : `LDSS_CODE_ZERO; // R5 R14 R16
    wire [7:0] dac2_next = run ? dac_src(chan_two.code_direct, chan_two.direct_code,
                                         look_two) : `LDSS_CODE_ZERO; // R6 R14 R16

    // ----------------------------------------
    // Power-up sequence
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ldss_pkg::LDSS_RECALL: state_next = ldss_pkg::LDSS_POWER; // R12
            ldss_pkg::LDSS_POWER:
                if (CONV_READY)
                    state_next = ldss_pkg::LDSS_QUALIFY;
            ldss_pkg::LDSS_QUALIFY:
                if (filt_update)
                    state_next = ldss_pkg::LDSS_RUN; // R13 R15
            ldss_pkg::LDSS_RUN: state_next = ldss_pkg::LDSS_RUN;
            default: state_next = ldss_pkg::LDSS_RECALL;
        endcase
    end

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            state_reg <= ldss_pkg::LDSS_RECALL; // R18
            dac1_reg <= `LDSS_CODE_ZERO; // R18
            dac2_reg <= `LDSS_CODE_ZERO;
            analog_reg <= 1'b0;
            conv_en_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            dac1_reg <= dac1_next;
            dac2_reg <= dac2_next;
            analog_reg <= (state_next != ldss_pkg::LDSS_RECALL); // R12
            conv_en_reg <= (state_next == ldss_pkg::LDSS_QUALIFY) ||
                           (state_next == ldss_pkg::LDSS_RUN);
        end
    end

    // ----------------------------------------
    // APB slave, one wait-free access phase
    // ----------------------------------------
    // Unmapped reads return zero with an error flag
    assign prdata_next = !idx_ok ? 32'h0000_0000 :
                         idx_ctrl ? {24'h00_0000, ctrl_reg[ctrl_sel]} :
                         (idx == `LDSS_IDX_STATUS) ? {24'h00_0000, result} :
                         is_table(idx) ? {24'h00_0000, tbl_rd} : 32'h0000_0000;
    // Status is read only, so a write to it is flagged
    assign pslverr_next = !idx_ok || (PWRITE && (idx == `LDSS_IDX_STATUS));

    always_ff @(posedge CLOCK)
    begin
        if (RST)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= PSEL && !PENABLE;
            prdata_reg <= (PSEL && !PENABLE && !PWRITE) ? prdata_next : prdata_reg;
            pslverr_reg <= PSEL && !PENABLE && pslverr_next;
        end
    end

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    ldss_tables u_tables
    (
        .clk(CLOCK),
        .factory_init(FACTORY_INIT),
        .wr_en(tbl_wr),
        .wr_tbl(table_of(idx)),
        .wr_row(row_of(idx)),
        .wr_data(PWDATA[7:0]),
        .rd_tbl(table_of(idx)),
        .rd_row(row_of(idx)),
        .rd_data(tbl_rd),
        .look_row_one(row_of(look_addr_one)),
        .look_row_two(row_of(look_addr_two)),
        .look_one(look_one),
        .look_two(look_two)
    );

    ldss_conv_filter u_filter
    (
        .clk(CLOCK),
        .rst(RST),
        .valid(conv_take),
        .data(CONV_DATA),
        .filter_disable(filt_off),
        .result(result),
        .update(filt_update)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign CONV_ENABLE = conv_en_reg;
    assign ANALOG_ENABLE = analog_reg;
    assign DAC1_CODE = dac1_reg;
    assign DAC2_CODE = dac2_reg;
    assign CHAN1_DIR = ctrl_reg[0][`LDSS_C0_DIR1]; // R9
    assign CHAN2_DIR = ctrl_reg[0][`LDSS_C0_DIR2]; // R9
    assign CHAN1_FS = ctrl_reg[5][`LDSS_C5_FS1_LO +: 2]; // R10 R11
    assign CHAN2_FS = ctrl_reg[5][`LDSS_C5_FS2_LO +: 2]; // R10 R11

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    dac_zero_a: assert property (@(posedge CLOCK) disable iff (RST) // R14
        !run |=> DAC1_CODE == `LDSS_CODE_ZERO && DAC2_CODE == `LDSS_CODE_ZERO)
        else $error("DAC code not zero before first lookup");
    direct_code_a: assert property (@(posedge CLOCK) disable iff (RST) // R8
        run && chan_one.code_direct |=> DAC1_CODE == $past(ctrl_reg[3]))
        else $error("channel one direct code not applied");
    conv_path_a: assert property (@(posedge CLOCK) disable iff (RST) // R3
        run && !chan_one.code_direct && !chan_one.row_direct |=>
        DAC1_CODE == $past(look_one) && $past(row_one) == $past(result[7:2]))
        else $error("channel one converter path wrong");
    row_direct_a: assert property (@(posedge CLOCK) disable iff (RST) // R4
        run && !chan_two.code_direct && chan_two.row_direct |=>
        DAC2_CODE == $past(look_two) && $past(row_two) == $past(ctrl_reg[2][5:0]))
        else $error("channel two row direct path wrong");
    chan_two_direct_a: assert property (@(posedge CLOCK) disable iff (RST) // R6
        run && chan_two.code_direct |=> DAC2_CODE == $past(ctrl_reg[4]))
        else $error("channel two direct code not applied");
    recall_first_a: assert property (@(posedge CLOCK) disable iff (RST) // R12
        $rose(ANALOG_ENABLE) |-> ctrl_reg[0] == ctrl_nv[0] && ctrl_reg[5] == ctrl_nv[5])
        else $error("analog enabled before recall");
    first_load_a: assert property (@(posedge CLOCK) disable iff (RST) // R13
        state_reg == ldss_pkg::LDSS_QUALIFY && filt_update |=> run)
        else $error("qualified result did not start run");
    restart_seq_a: assert property (@(posedge CLOCK) // R18
        $past(RST) && !RST |-> recall && DAC1_CODE == `LDSS_CODE_ZERO && !ANALOG_ENABLE)
        else $error("reset did not restart sequence");
    apb_ready_a: assert property (@(posedge CLOCK) disable iff (RST)
        PSEL && !PENABLE |=> PREADY)
        else $error("no ready in access phase");
    // Single access cycle: a stretched ready would double a write
    ready_pulse_a: assert property (@(posedge CLOCK) disable iff (RST)
        PREADY |=> !PREADY)
        else $error("ready held too long");
    error_ready_a: assert property (@(posedge CLOCK) disable iff (RST)
        PSLVERR |-> PREADY)
        else $error("error flag without ready");
    unmapped_err_a: assert property (@(posedge CLOCK) disable iff (RST)
        PSEL && !PENABLE && !idx_ok |=> PSLVERR)
        else $error("unmapped access not flagged");

    // ----------------------------------------
    // Sequence checks
    // ----------------------------------------
    analog_wait_a: assert property (@(posedge CLOCK) disable iff (RST) // R12
        recall |-> !ANALOG_ENABLE && !CONV_ENABLE)
        else $error("analog on during recall");
    conv_wait_a: assert property (@(posedge CLOCK) disable iff (RST) // R13
        state_reg == ldss_pkg::LDSS_POWER && !CONV_READY |=> !CONV_ENABLE)
        else $error("converter on before ready");
    conv_on_a: assert property (@(posedge CLOCK) disable iff (RST) // R13
        state_reg == ldss_pkg::LDSS_POWER && CONV_READY |=> CONV_ENABLE)
        else $error("converter not started");
    run_hold_a: assert property (@(posedge CLOCK) disable iff (RST) // R13
        run |=> run)
        else $error("run state left without reset");
    zero_before_run_a: assert property (@(posedge CLOCK) disable iff (RST) // R14
        !run |-> DAC1_CODE == `LDSS_CODE_ZERO && DAC2_CODE == `LDSS_CODE_ZERO)
        else $error("DAC code loaded before run");
    // Status only moves on a qualified update
    status_update_a: assert property (@(posedge CLOCK) disable iff (RST) // R17
        $changed(result) |-> filt_update)
        else $error("status changed without update");

    // ----------------------------------------
    // Channel path checks
    // ----------------------------------------
    chan_two_conv_a: assert property (@(posedge CLOCK) disable iff (RST) // R6 R7
        run && !chan_two.code_direct && !chan_two.row_direct |=>
        DAC2_CODE == $past(look_two) && $past(row_two) == $past(result[7:2]))
        else $error("channel two converter path wrong");
    chan_one_row_a: assert property (@(posedge CLOCK) disable iff (RST) // R4
        run && !chan_one.code_direct && chan_one.row_direct |=>
        DAC1_CODE == $past(look_one) && $past(row_one) == $past(ctrl_reg[1][5:0]))
        else $error("channel one row direct path wrong");
endmodule // ldss_top

// ==== bench/ldss_conv_model.sv ====
// Behavioural converter that finishes conversions on request
`timescale 1ns/1ps
module ldss_conv_model
(
    // Clock
    input wire logic clk,
    // Converter side
    input wire logic enable,
    output logic valid,
    output logic [7:0] data
);
    initial
    begin
        valid = 1'b0;
        data = 8'h00;
    end

    // ----------------------------------------
    // Conversion
    // ----------------------------------------
    // A conversion only finishes once the converter is allowed to run
    task automatic convert(input logic [7:0] v, input integer idle);
        while (enable !== 1'b1)
        begin
            @(posedge clk);
        end
        @(posedge clk);
        repeat (idle) @(posedge clk);
        valid <= 1'b1;
        data <= v;
        @(posedge clk);
        valid <= 1'b0;
        // Result is not held after its pulse
        data <= ~v;
    endtask
endmodule // ldss_conv_model

// ==== bench/lut_dac_source_select_test.sv ====
// Self-checking bench for the table and source select block
`timescale 1ns/1ps
`include "ldss_defs.svh"
module lut_dac_source_select_test;
    logic clock;
    logic rst = 1'b1;
    logic factory_init = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [10:0] paddr = 11'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic conv_ready = 1'b0;
    logic [31:0] prdata, rdata;
    logic pready, pslverr, rerr, conv_valid, conv_enable, analog_enable;
    logic chan1_dir, chan2_dir;
    logic [7:0] conv_data, dac1_code, dac2_code, v, w;
    logic [1:0] chan1_fs, chan2_fs;
    logic [7:0] tbl [0:1][0:63];
    logic [7:0] ctrl [0:5];
    integer n_errors = 0;
    integer samples_checked = 0;
    integer seed = 32'hca301bb2;
    integer i, k;

    ldss_top ldss_top_inst
    (
        .CLOCK(clock), .RST(rst), .FACTORY_INIT(factory_init),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CONV_READY(conv_ready), .CONV_VALID(conv_valid), .CONV_DATA(conv_data),
        .CONV_ENABLE(conv_enable), .ANALOG_ENABLE(analog_enable),
        .DAC1_CODE(dac1_code), .DAC2_CODE(dac2_code), .CHAN1_DIR(chan1_dir),
        .CHAN2_DIR(chan2_dir), .CHAN1_FS(chan1_fs), .CHAN2_FS(chan2_fs)
    );

    ldss_conv_model ldss_conv_model_inst
    (
        .clk(clock), .enable(conv_enable), .valid(conv_valid), .data(conv_data)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Setup one edge after the call, so psel never toggles twice in one step
    task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
        begin
            @(posedge clock);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task set_ctrl(input integer j, input logic [7:0] d);
        ctrl[j] = d;
        apb(1'b1, 9'(`LDSS_IDX_CTRL0 + j), d);
    endtask

    function automatic logic [7:0] exp_code(input integer ch, input logic [7:0] res);
        logic [5:0] row;
        row = ctrl[5][4 + 2 * ch] ? ctrl[1 + ch][5:0] : res[7:2];
        return ctrl[5][5 + 2 * ch] ? ctrl[3 + ch] : tbl[ch][row];
    endfunction

    task check_outputs(input logic [7:0] res);
        repeat (3) @(posedge clock);
        check(dac1_code, exp_code(0, res), "dac one");
        check(dac2_code, exp_code(1, res), "dac two");
        check({chan2_dir, chan1_dir}, ctrl[0][1:0], "direction");
        check({chan2_fs, chan1_fs}, ctrl[5][3:0], "full scale");
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #2000000;
        n_errors++;
        complete_run();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        for (i = 0; i < 6; i++) ctrl[i] = 8'h00;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        factory_init <= 1'b0;
        repeat (2) @(posedge clock);
        check(analog_enable, 1'b1, "analog on after recall");
        check(conv_enable, 1'b0, "converter held off");
        for (i = 0; i < 128; i++)
        begin
            tbl[i / 64][i % 64] = 8'($random(seed));
            apb(1'b1, 9'(`LDSS_TBL1_BASE + i), tbl[i / 64][i % 64]);
        end
        apb(1'b0, 9'(`LDSS_TBL2_BASE + 5), 8'h00);
        check(rdata, {24'h000000, tbl[1][5]}, "table read");
        apb(1'b0, 9'h000, 8'h00);
        check(rerr, 1'b1, "unmapped error");
        check(rdata, 32'h0, "unmapped read");
        apb(1'b1, `LDSS_IDX_STATUS, 8'hA5);
        check(rerr, 1'b1, "status write refused");
        $display("test registers done");

        // Filtered qualification with a mismatch in the middle
        conv_ready <= 1'b1;
        v = 8'($random(seed));
        w = v ^ 8'h80;
        for (i = 0; i < 3; i++) ldss_conv_model_inst.convert(v ^ 8'(i), i % 2);
        ldss_conv_model_inst.convert(w, 0);
        repeat (4) @(posedge clock);
        check({dac2_code, dac1_code}, 16'h0000, "codes held zero");
        for (i = 0; i < 3; i++) ldss_conv_model_inst.convert(w ^ 8'(i), 0);
        check_outputs(w);
        check(dac1_code, tbl[0][w[7:2]], "row one");
        check(dac2_code, tbl[1][w[7:2]], "row two");
        apb(1'b0, `LDSS_IDX_STATUS, 8'h00);
        check(rdata, {24'h000000, w ^ 8'h02}, "qualified result");
        $display("test qualify done");

        // Every select combination with random registers
        for (k = 0; k < 16; k++)
        begin
            for (i = 0; i < 5; i++) set_ctrl(i, 8'($random(seed)) & 8'h7F);
            set_ctrl(5, {4'(k), 4'($random(seed))});
            check_outputs(w ^ 8'h02);
        end
        $display("test selects done");

        // New reset with recalled selects and filter off
        set_ctrl(0, 8'h83);
        set_ctrl(5, 8'h5B);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        check({chan2_dir, chan1_dir, chan2_fs, chan1_fs}, 6'h3B, "recalled");
        check({dac2_code, dac1_code}, 16'h0000, "zero after reset");
        v = 8'($random(seed));
        ldss_conv_model_inst.convert(v, 2);
        check_outputs(v);
        check(conv_enable, 1'b1, "converter running");
        apb(1'b0, `LDSS_IDX_STATUS, 8'h00);
        check(rdata, {24'h000000, v}, "unfiltered result");
        $display("test restart done");
        complete_run();
    end
endmodule // lut_dac_source_select_test
